//--- hdl/timer_two_consts.svh
/*
  Offsets, field positions, reset values, vectors and divider counts of the
  timer compare/capture block. Assumes byte-wide special registers addressed
  by an 8-bit offset.
*/
`ifndef TIMER_TWO_CONSTS_SVH
`define TIMER_TWO_CONSTS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define OFS_IRQ_EN_LOW 8'hA8
`define OFS_IRQ_EN_CHAN 8'hB8
`define OFS_IRQ_REQ 8'hC0
`define OFS_CC_ENABLE 8'hC1
`define OFS_CH1_LOW 8'hC2
`define OFS_CH1_HIGH 8'hC3
`define OFS_CH2_LOW 8'hC4
`define OFS_CH2_HIGH 8'hC5
`define OFS_CH3_LOW 8'hC6
`define OFS_CH3_HIGH 8'hC7
`define OFS_TIMER_CTRL 8'hC8
`define OFS_RC_LOW 8'hCA
`define OFS_RC_HIGH 8'hCB
`define OFS_CNT_LOW 8'hCC
`define OFS_CNT_HIGH 8'hCD

// ------------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------------
`define BIT_GLOBAL_EN 7
`define BIT_MAIN_EN 5
`define BIT_EXT_RL_EN 7
`define BIT_RESERVED_CHAN 6
`define BIT_CMP_BASE 2
`define BIT_EXT_RL_FLAG 7
`define BIT_MAIN_FLAG 6
`define BIT_PRESCALE 7
`define BIT_CMP0_COND 6
`define BIT_CMP_METHOD 2
`define POS_RELOAD_MODE 3
`define POS_CLK_SRC 0
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define COUNT_MAX 16'hFFFF

// ------------------------------------------------------------------
// vectors and prescaler counts
// ------------------------------------------------------------------
`define VEC_NONE 8'h00
`define VEC_MAIN 8'h2B
`define VEC_CMP0 8'h53
`define VEC_CMP1 8'h5B
`define VEC_CMP2 8'h63
`define VEC_CMP3 8'h6B
`define PRE_DIV12 5'h0C
`define PRE_DIV24 5'h18

`endif

//--- hdl/timer_two_pkg.sv
/*
  Types of the timer compare/capture block: bus request, pin bundle and the
  field encodings. Assumes the constants header sits beside it.
*/
`default_nettype none

package timer_two_pkg;
	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr; // register offset
		logic [7:0] wdata; // write data
		logic wr; // write strobe
		logic rd; // read strobe
	} bus_req_t;

	typedef struct packed {
		logic count_pin; // external count / gate pin
		logic reload_pin; // external reload pin
		logic [3:0] capture_pin; // per-channel capture pins
	} pins_t;

	// ------------------------------------------------------------------
	// field encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_OFF = 2'h0,
		SRC_PRESCALED = 2'h1,
		SRC_PIN = 2'h2,
		SRC_GATED = 2'h3
	} clk_src_t;

	typedef enum logic [1:0] {
		RL_OFF0 = 2'h0,
		RL_OFF1 = 2'h1,
		RL_AUTO = 2'h2,
		RL_PIN = 2'h3
	} reload_mode_t;

	typedef enum logic [1:0] {
		FN_OFF = 2'h0,
		FN_CAP_PIN = 2'h1,
		FN_COMPARE = 2'h2,
		FN_CAP_WRITE = 2'h3
	} chan_fn_t;
endpackage

`default_nettype wire

//--- hdl/timer_two_compare_capture_irq.sv
/*
  Sixteen-bit up-counting timer with a reload/compare register, three more
  compare/capture channels and their interrupt enables and request flags.
  Assumes a processor core on sys_clk_in that drives the byte register port
  and returns one acknowledge pulse per serviced compare vector.
*/
// Behaviour
// - three channel values, byte-wise RW, reset zero
// - global enable gates every block interrupt
// - main enable covers overflow and external reload
// - external reload interrupt has own enable
// - per-channel compare enables; reserved bit reads zero
// - hardware sets external reload request flag
// - hardware sets main timer request flag
// - compare flags set on their channel events
// - main and reload flags cleared by software
// - compare flags cleared when interrupt serviced
// - main interrupt vectors to 0x2B
// - compare vectors 0x53, 0x5B, 0x63, 0x6B
// - clock source: prescaled, pin, gated prescaled
// - prescale divides by twelve or twenty-four
// - reload on overflow or reload pin fall
// - control bit picks direct or indirect output
// - channel zero on becoming equal or unequal
// - field codes: off, pin capture, compare, write capture
// - capture copies counter; reload loads register
`include "timer_two_consts.svh"
`default_nettype none

module timer_two_compare_capture_irq (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// register port
	input wire timer_two_pkg::bus_req_t bus_in,
	output var logic [7:0] rd_data_out,
	// pins from outside
	input wire timer_two_pkg::pins_t pins_in,
	// core side
	input wire logic [3:0] cmp_ack_in,
	input wire logic [3:0] port_level_in,
	output var logic [3:0] compare_out,
	output var logic irq_req_out,
	output var logic [7:0] irq_vector_out
);
	import timer_two_pkg::*;

	// assertion clock and reset, declared ahead of the channel checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	// ------------------------------------------------------------------
	// registers and shared signals
	// ------------------------------------------------------------------
	localparam logic [7:0] LOW_OFS [4] = '{`OFS_RC_LOW, `OFS_CH1_LOW, `OFS_CH2_LOW, `OFS_CH3_LOW};
	localparam logic [7:0] HIGH_OFS [4] = '{`OFS_RC_HIGH, `OFS_CH1_HIGH, `OFS_CH2_HIGH, `OFS_CH3_HIGH};

	logic [7:0] irq_en_low_q; // global and main enables live here
	logic [7:0] irq_en_chan_q; // reload and compare enables
	logic [7:0] timer_ctrl_q; // timer control
	logic [7:0] cc_enable_q; // two bits of function per channel
	logic [15:0] cnt_q; // the counter
	logic [15:0] val_q [4]; // channel 0 is the reload/compare pair
	logic ext_flag_q; // external reload request
	logic main_flag_q; // main timer request
	logic [3:0] cmp_flag_q; // compare requests
	logic [3:0] match; // one-cycle compare events
	logic [7:0] rd_mux; // read data before the output flop
	logic wr_flags; // software write to the request register
	pins_t sync1_q, sync2_q, prev_q; // pin synchroniser and history
	logic [4:0] pre_q; // prescaler count
	logic pre_tick; // one-cycle prescaled enable
	logic count_en; // counter advances this cycle
	logic ovf; // counter wraps this cycle
	logic ext_rl; // reload pin fell in pin reload mode
	logic reload_now; // counter takes the reload value
	logic main_pend, global_en;
	logic [3:0] cmp_pend;
	logic [15:0] rc_val; // helper view of channel 0
	clk_src_t clk_src;
	reload_mode_t rl_mode;

	assign wr_flags = bus_in.wr && (bus_in.addr == `OFS_IRQ_REQ);
	assign clk_src = clk_src_t'(timer_ctrl_q[`POS_CLK_SRC +: 2]);
	assign rl_mode = reload_mode_t'(timer_ctrl_q[`POS_RELOAD_MODE +: 2]);
	assign rc_val = val_q[0];

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	// two flops before any use; prev_q only looks at the second stage
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= pins_in;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// ------------------------------------------------------------------
	// prescaler and count enable
	// ------------------------------------------------------------------
	// >= guards a switch from /24 to /12 while the count sits above 11
	assign pre_tick = timer_ctrl_q[`BIT_PRESCALE] ? (pre_q >= `PRE_DIV24 - 5'h01)
		: (pre_q >= `PRE_DIV12 - 5'h01);

	// prescaler runs freely so the rate is fixed regardless of source
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pre_q <= 5'h00;
		end else if (pre_tick) begin
			pre_q <= 5'h00;
		end else begin
			pre_q <= pre_q + 5'h01;
		end
	end

	// source select; the pin source counts on its falling edge
	always_comb begin
		unique case (clk_src)
			SRC_PRESCALED: count_en = pre_tick;
			SRC_PIN: count_en = prev_q.count_pin && !sync2_q.count_pin;
			SRC_GATED: count_en = pre_tick && sync2_q.count_pin;
			SRC_OFF: count_en = 1'b0;
		endcase
	end

	assign ovf = count_en && (cnt_q == `COUNT_MAX);
	assign ext_rl = (rl_mode == RL_PIN) && prev_q.reload_pin && !sync2_q.reload_pin;
	assign reload_now = ext_rl || (ovf && (rl_mode == RL_AUTO));

	// ------------------------------------------------------------------
	// counter
	// ------------------------------------------------------------------
	// software write beats reload, reload beats counting
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= `RESET_WORD;
		end else if (bus_in.wr && bus_in.addr == `OFS_CNT_LOW) begin
			cnt_q[7:0] <= bus_in.wdata;
		end else if (bus_in.wr && bus_in.addr == `OFS_CNT_HIGH) begin
			cnt_q[15:8] <= bus_in.wdata;
		end else if (reload_now) begin
			cnt_q <= val_q[0];
		end else if (count_en) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// control and enable registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_en_low_q <= `RESET_BYTE;
			irq_en_chan_q <= `RESET_BYTE;
			timer_ctrl_q <= `RESET_BYTE;
			cc_enable_q <= `RESET_BYTE;
		end else if (bus_in.wr) begin
			unique case (bus_in.addr)
				`OFS_IRQ_EN_LOW: irq_en_low_q <= bus_in.wdata;
				// reserved bit is never stored so it always reads zero
				`OFS_IRQ_EN_CHAN: irq_en_chan_q <= bus_in.wdata & 8'hBF;
				`OFS_TIMER_CTRL: timer_ctrl_q <= bus_in.wdata;
				`OFS_CC_ENABLE: cc_enable_q <= bus_in.wdata;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// main and reload request flags
	// ------------------------------------------------------------------
	// hardware set wins over a software clear in the same cycle;
	// there is no automatic clear, the service routine writes zero
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ext_flag_q <= 1'b0;
			main_flag_q <= 1'b0;
		end else begin
			ext_flag_q <= ext_rl || (wr_flags ? bus_in.wdata[`BIT_EXT_RL_FLAG] : ext_flag_q);
			main_flag_q <= ovf || (wr_flags ? bus_in.wdata[`BIT_MAIN_FLAG] : main_flag_q);
		end
	end

	// ------------------------------------------------------------------
	// channels
	// ------------------------------------------------------------------
	for (genvar i = 0; i < 4; i++) begin : g_chan
		chan_fn_t fn;
		logic wr_lo, wr_hi, pin_edge, capture, eq, eq_q;
		assign fn = chan_fn_t'(cc_enable_q[2*i +: 2]);
		assign wr_lo = bus_in.wr && (bus_in.addr == LOW_OFS[i]);
		assign wr_hi = bus_in.wr && (bus_in.addr == HIGH_OFS[i]);
		// channel 0 pin capture edge follows the condition bit
		assign pin_edge = (i == 0 && !timer_ctrl_q[`BIT_CMP0_COND])
			? (prev_q.capture_pin[i] && !sync2_q.capture_pin[i])
			: (!prev_q.capture_pin[i] && sync2_q.capture_pin[i]);
		assign capture = (fn == FN_CAP_PIN && pin_edge) || (fn == FN_CAP_WRITE && wr_lo);
		assign eq = (cnt_q == val_q[i]);
		// channel 0 may fire on leaving equality; others on reaching it
		assign match[i] = (fn == FN_COMPARE) && ((i == 0 && !timer_ctrl_q[`BIT_CMP0_COND])
			? (eq_q && !eq) : (eq && !eq_q));

		// value bytes; a write to the low byte in write-capture mode
		// records the counter instead of the data
		always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				val_q[i] <= `RESET_WORD;
			end else if (capture) begin
				val_q[i] <= cnt_q;
			end else if (wr_lo) begin
				val_q[i][7:0] <= bus_in.wdata;
			end else if (wr_hi) begin
				val_q[i][15:8] <= bus_in.wdata;
			end
		end

		// equality history for edge detection
		always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				eq_q <= 1'b0;
			end else begin
				eq_q <= eq;
			end
		end

		// compare flag: set wins over service clear and software write
		always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				cmp_flag_q[i] <= 1'b0;
			end else begin
				cmp_flag_q[i] <= match[i] || (wr_flags ? bus_in.wdata[`BIT_CMP_BASE + i]
					: (cmp_flag_q[i] && !cmp_ack_in[i]));
			end
		end

		// compare output: direct follows the comparison, indirect loads
		// the prepared port level on reaching equality
		always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				compare_out[i] <= 1'b0;
			end else if (fn == FN_COMPARE) begin
				if (!timer_ctrl_q[`BIT_CMP_METHOD]) begin
					compare_out[i] <= (cnt_q >= val_q[i]);
				end else if (eq && !eq_q) begin
					compare_out[i] <= port_level_in[i];
				end
			end
		end

		assign cmp_pend[i] = cmp_flag_q[i] && irq_en_chan_q[`BIT_CMP_BASE + i];

		AST_CAP_WRITE: assert property ((fn == FN_CAP_WRITE && wr_lo) |=> val_q[i] == $past(cnt_q))
			else $error("write capture did not record counter");
		AST_SVC_CLEAR: assert property ((cmp_ack_in[i] && !match[i] && !wr_flags) |=> !cmp_flag_q[i])
			else $error("serviced compare flag not cleared");
		AST_MATCH_FLAG: assert property (match[i] |=> cmp_flag_q[i])
			else $error("compare event lost");
	end

	// ------------------------------------------------------------------
	// interrupt request and vector
	// ------------------------------------------------------------------
	assign global_en = irq_en_low_q[`BIT_GLOBAL_EN];
	assign main_pend = irq_en_low_q[`BIT_MAIN_EN]
		&& (main_flag_q || (ext_flag_q && irq_en_chan_q[`BIT_EXT_RL_EN]));

	// main request takes priority, then channel 0 up to 3
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_req_out <= 1'b0;
			irq_vector_out <= `VEC_NONE;
		end else begin
			irq_req_out <= global_en && (main_pend || (|cmp_pend));
			if (!global_en) begin
				irq_vector_out <= `VEC_NONE;
			end else if (main_pend) begin
				irq_vector_out <= `VEC_MAIN;
			end else if (cmp_pend[0]) begin
				irq_vector_out <= `VEC_CMP0;
			end else if (cmp_pend[1]) begin
				irq_vector_out <= `VEC_CMP1;
			end else if (cmp_pend[2]) begin
				irq_vector_out <= `VEC_CMP2;
			end else if (cmp_pend[3]) begin
				irq_vector_out <= `VEC_CMP3;
			end else begin
				irq_vector_out <= `VEC_NONE;
			end
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	// unmapped offsets read zero
	always_comb begin
		unique case (bus_in.addr)
			`OFS_IRQ_EN_LOW: rd_mux = irq_en_low_q;
			`OFS_IRQ_EN_CHAN: rd_mux = irq_en_chan_q;
			`OFS_IRQ_REQ: rd_mux = {ext_flag_q, main_flag_q, cmp_flag_q, 2'b00};
			`OFS_CC_ENABLE: rd_mux = cc_enable_q;
			`OFS_CH1_LOW: rd_mux = val_q[1][7:0];
			`OFS_CH1_HIGH: rd_mux = val_q[1][15:8];
			`OFS_CH2_LOW: rd_mux = val_q[2][7:0];
			`OFS_CH2_HIGH: rd_mux = val_q[2][15:8];
			`OFS_CH3_LOW: rd_mux = val_q[3][7:0];
			`OFS_CH3_HIGH: rd_mux = val_q[3][15:8];
			`OFS_TIMER_CTRL: rd_mux = timer_ctrl_q;
			`OFS_RC_LOW: rd_mux = val_q[0][7:0];
			`OFS_RC_HIGH: rd_mux = val_q[0][15:8];
			`OFS_CNT_LOW: rd_mux = cnt_q[7:0];
			`OFS_CNT_HIGH: rd_mux = cnt_q[15:8];
			default: rd_mux = 8'h00;
		endcase
	end

	// data stand for the one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data_out <= 8'h00;
		end else if (bus_in.rd) begin
			rd_data_out <= rd_mux;
		end else begin
			rd_data_out <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	AST_GLOBAL_GATE: assert property (irq_req_out |-> $past(global_en))
		else $error("request without global enable");
	AST_MAIN_VECTOR: assert property ((global_en && main_pend) |=> irq_req_out && irq_vector_out == `VEC_MAIN)
		else $error("main request missing or misvectored");
	AST_CMP0_VECTOR: assert property ((global_en && !main_pend && cmp_pend[0]) |=> irq_vector_out == `VEC_CMP0)
		else $error("channel 0 misvectored");
	AST_EXT_FLAG: assert property (ext_rl |=> ext_flag_q ##0 cnt_q == $past(rc_val) || $past(bus_in.wr))
		else $error("external reload not flagged or not loaded");
	AST_OVF_FLAG: assert property (ovf |=> main_flag_q)
		else $error("overflow not flagged");
	AST_MAIN_STICKY: assert property ((main_flag_q && !wr_flags) |=> main_flag_q)
		else $error("main flag cleared without software");
	AST_AUTO_RELOAD: assert property ((ovf && rl_mode == RL_AUTO && !bus_in.wr) |=> cnt_q == $past(rc_val))
		else $error("auto reload did not load");
	AST_RESERVED_ZERO: assert property ((bus_in.rd && bus_in.addr == `OFS_IRQ_EN_CHAN) |=> !rd_data_out[6])
		else $error("reserved enable bit read as one");
	AST_READ_ONCE: assert property (!bus_in.rd |=> rd_data_out == 8'h00)
		else $error("read data held past its cycle");
	AST_PRESCALE_GAP: assert property ((pre_tick && !timer_ctrl_q[`BIT_PRESCALE]) |=> !pre_tick [*8])
		else $error("prescaled enable too frequent");

	COV_OVF_IRQ: cover property (ovf ##[1:3] irq_req_out);
	COV_EXT_RELOAD: cover property (ext_rl ##1 ext_flag_q);
	COV_MATCH: cover property (match[0] ##[1:3] irq_vector_out == `VEC_CMP0);
	COV_CAPTURE: cover property (g_chan[1].capture);
endmodule

`default_nettype wire

//--- verification/core_model.sv
/*
  Processor core stand-in: services compare vectors by pulsing the matching
  acknowledge line. Assumes one clock shared with the timer block.
*/
`default_nettype none

module core_model #(
	parameter int ACK_DELAY = 3 // cycles from request to service
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// request side
	input wire logic irq_req_in,
	input wire logic [7:0] irq_vector_in,
	// service side
	output logic [3:0] cmp_ack_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------------
	// vector servicing
	// ------------------------------------------------------------------
	// main vector is left alone: software clears those flags itself
	initial begin
		cmp_ack_out = 4'h0;
		forever begin
			@(posedge sys_clk_in);
			if (rst_b_in === 1'b1 && irq_req_in === 1'b1) begin
				// compare vectors sit eight apart from the channel 0 one
				case (irq_vector_in)
					8'h53, 8'h5B, 8'h63, 8'h6B: begin
						repeat (ACK_DELAY) @(posedge sys_clk_in);
						cmp_ack_out <= 4'h1 << ((irq_vector_in - 8'h53) >> 3);
						@(posedge sys_clk_in);
						cmp_ack_out <= 4'h0;
						// let the dropped flag reach the request line
						repeat (3) @(posedge sys_clk_in);
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule

`default_nettype wire

//--- verification/tb_top.sv
/*
  Self-checking bench of the timer compare/capture block. Assumes the design
  package is compiled first; drives the byte register port and pins.
*/
`default_nettype none

module tb_top;
	import timer_two_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic clk = 1'b0; // 100 MHz system clock
	logic rst_b = 1'b0; // active low reset
	bus_req_t bus = '0; // register request
	pins_t pins = '{count_pin: 1'b0, reload_pin: 1'b1, capture_pin: 4'h0};
	logic [7:0] rdat; // read data
	logic [3:0] ack; // service pulses from the core
	logic [3:0] cmp_q; // compare outputs, channel 1 checked in the compare test
	logic irq; // interrupt request
	logic [7:0] vec; // interrupt vector
	int n_fail = 0;
	int num_checks = 0;

	`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
		$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

	always #5 clk = ~clk;

	timer_two_compare_capture_irq dut_u (
		.sys_clk_in(clk),
		.rst_b_in(rst_b),
		.bus_in(bus),
		.rd_data_out(rdat),
		.pins_in(pins),
		.cmp_ack_in(ack),
		.port_level_in(4'h0),
		.compare_out(cmp_q),
		.irq_req_out(irq),
		.irq_vector_out(vec)
	);

	core_model #(.ACK_DELAY(3)) core_u (
		.sys_clk_in(clk),
		.rst_b_in(rst_b),
		.irq_req_in(irq),
		.irq_vector_in(vec),
		.cmp_ack_out(ack)
	);

	// ------------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	// read data stand only in the cycle after the strobe is taken
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		`CHK(nm, e, rdat)
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_and_rw();
		logic [7:0] a;
		for (int i = 0; i < 6; i++) begin
			a = 8'hC2 + 8'(i);
			rd(a, 8'h00, "chan reset");
			wr(a, 8'h5A ^ 8'(i));
		end
		rd(8'hA8, 8'h00, "en low reset");
		rd(8'hB8, 8'h00, "en chan reset");
		rd(8'hC0, 8'h00, "req reset");
		for (int i = 0; i < 6; i++) rd(8'hC2 + 8'(i), 8'h5A ^ 8'(i), "chan rw");
		wr(8'hB8, 8'hFF);
		rd(8'hB8, 8'hBF, "reserved bit");
		wr(8'hB8, 8'h00);
		rd(8'hFF, 8'h00, "unmapped");
		$display("test reset_and_rw done");
	endtask

	task automatic t_write_capture();
		wr(8'hCC, 8'h34);
		wr(8'hCD, 8'h12);
		wr(8'hC1, 8'hC0);
		wr(8'hC6, 8'hEE);
		rd(8'hC6, 8'h34, "capture low");
		rd(8'hC7, 8'h12, "capture high");
		wr(8'hC1, 8'h00);
		$display("test write_capture done");
	endtask

	task automatic t_clock_sources();
		wr(8'hCC, 8'h00);
		wr(8'hCD, 8'h00);
		wr(8'hC8, 8'h02);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk) pins.count_pin <= 1'b1;
			cycles(4);
			@(posedge clk) pins.count_pin <= 1'b0;
			cycles(4);
		end
		wr(8'hC8, 8'h03);
		cycles(60);
		wr(8'hC8, 8'h00);
		rd(8'hCC, 8'h05, "pin count, gate shut");
		$display("test clock_sources done");
	endtask

	task automatic t_reload_pin();
		wr(8'hCA, 8'h78);
		wr(8'hCB, 8'h56);
		wr(8'hC8, 8'h18);
		@(posedge clk) pins.reload_pin <= 1'b0;
		cycles(8);
		rd(8'hCC, 8'h78, "reload low");
		rd(8'hCD, 8'h56, "reload high");
		rd(8'hC0, 8'h80, "reload flag");
		cycles(20);
		rd(8'hC0, 8'h80, "reload flag kept");
		wr(8'hC0, 8'h00);
		rd(8'hC0, 8'h00, "reload flag cleared");
		@(posedge clk) pins.reload_pin <= 1'b1;
		wr(8'hC8, 8'h00);
		$display("test reload_pin done");
	endtask

	task automatic t_overflow_irq();
		wr(8'hCC, 8'hFE);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h11);
		cycles(60);
		wr(8'hC8, 8'h00);
		rd(8'hC0, 8'h40, "overflow flag");
		rd(8'hCD, 8'h56, "auto reload high");
		wr(8'hA8, 8'h20);
		cycles(3);
		#1;
		`CHK("irq without global", 1'b0, irq)
		wr(8'hA8, 8'hA0);
		cycles(2);
		#1;
		`CHK("irq main", 1'b1, irq)
		`CHK("vector main", 8'h2B, vec)
		wr(8'hC0, 8'h00);
		cycles(2);
		#1;
		`CHK("irq cleared", 1'b0, irq)
		wr(8'hC0, 8'hFF);
		rd(8'hC0, 8'hFC, "flags low bits");
		wr(8'hC0, 8'h00);
		wr(8'hA8, 8'h00);
		$display("test overflow_irq done");
	endtask

	task automatic t_compare_service();
		wr(8'hCC, 8'h00);
		wr(8'hCD, 8'h00);
		wr(8'hC2, 8'h03);
		wr(8'hC3, 8'h00);
		wr(8'hC1, 8'h08);
		wr(8'hB8, 8'h08);
		wr(8'hA8, 8'h80);
		wr(8'hC8, 8'h01);
		for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
		#1;
		`CHK("irq compare", 1'b1, irq)
		`CHK("vector ch1", 8'h5B, vec)
		`CHK("compare out ch1", 1'b1, cmp_q[1])
		for (int i = 0; i < 40 && irq !== 1'b0; i++) @(posedge clk);
		wr(8'hC8, 8'h00);
		rd(8'hC0, 8'h00, "flag cleared by service");
		wr(8'hA8, 8'h00);
		$display("test compare_service done");
	endtask

	// ------------------------------------------------------------------
	// closing and main sequence
	// ------------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog: tests need a few hundred cycles, allow many more
	initial begin
		#200000;
		n_fail++;
		conclude();
	end

	initial begin
		cycles(4);
		@(posedge clk) rst_b <= 1'b1;
		t_reset_and_rw();
		t_write_capture();
		t_clock_sources();
		t_reload_pin();
		t_overflow_irq();
		t_compare_service();
		conclude();
	end
endmodule

`default_nettype wire
